// [include/tlb_mmap_defs.svh]
// constants for the memory-mapped translation buffer access block
// assumes a 32-bit word-addressed AHB-Lite slave view of the control space
`ifndef TLB_MMAP_DEFS_SVH
`define TLB_MMAP_DEFS_SVH

// ----------------------------------------------------------------
// address decode
// ----------------------------------------------------------------
`define WIN_MSB 31
`define WIN_LSB 24
`define WIN_TAG 8'hF2
`define WIN_DATA 8'hF3
`define IDX_MSB 16
`define IDX_LSB 12
`define WAY_MSB 9
`define WAY_LSB 8
`define ASSOC_BIT 7
`define CTRL_ADDR 32'hFF00_0010

// ----------------------------------------------------------------
// tag word layout
// ----------------------------------------------------------------
`define TAG_VPNH_MSB 31
`define TAG_VPNH_LSB 17
`define TAG_VPNL_MSB 11
`define TAG_VPNL_LSB 10
`define VALID_BIT 8
`define TAG_SPACE_MSB 7
`define TAG_SPACE_LSB 0
`define TAG_MASK 32'hFFFE_0DFF

// ----------------------------------------------------------------
// data word layout
// ----------------------------------------------------------------
`define DAT_FRAME_MSB 28
`define DAT_FRAME_LSB 10
`define DAT_RIGHTS_MSB 6
`define DAT_RIGHTS_LSB 5
`define DAT_SIZE_BIT 4
`define DAT_CACHE_BIT 3
`define DAT_DIRTY_BIT 2
`define DAT_SHARE_BIT 1
`define DAT_MASK 32'h1FFF_FD7E

// ----------------------------------------------------------------
// translation control register
// ----------------------------------------------------------------
`define CTRL_EN_BIT 0
`define CTRL_HASH_BIT 2
`define CTRL_SPACE_MSB 15
`define CTRL_SPACE_LSB 8
`define CTRL_MASK 32'h0000_FF05
`define HSIZE_WORD 3'h2

`endif

// [include/tlb_mmap_pkg.sv]
// types shared by the translation buffer access block and its storage
// assumes tlb_mmap_defs.svh on the include path
`default_nettype none
`include "tlb_mmap_defs.svh"

package tlb_mmap_pkg;

	typedef struct packed {
		logic [`TAG_VPNH_MSB-`TAG_VPNH_LSB:0] vpage_hi;
		logic [`TAG_VPNL_MSB-`TAG_VPNL_LSB:0] vpage_lo;
		logic [`TAG_SPACE_MSB-`TAG_SPACE_LSB:0] space_id;
	} tag_entry_t;

	typedef struct packed {
		logic [`DAT_FRAME_MSB-`DAT_FRAME_LSB:0] frame;
		logic [`DAT_RIGHTS_MSB-`DAT_RIGHTS_LSB:0] rights;
		logic page_size;
		logic cacheable;
		logic dirty;
		logic share;
	} data_entry_t;

	typedef struct packed {
		logic [31:0] addr;
		logic write;
		logic word;
		logic priv;
	} bus_phase_t;

	typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ_WAIT, ST_READ_DONE} bus_state_t;

endpackage : tlb_mmap_pkg

`default_nettype wire

// [design/tlb_set_store.sv]
// per-way tag, data and valid storage of the translation buffer
// assumes one write port and two combinational set-read ports
`timescale 1ns/1ps
`default_nettype none

module tlb_set_store #(
	parameter int SETS = 32,
	parameter int WAYS = 4,
	parameter int IW = 5
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WAYS-1:0] i_tag_we,
	input wire logic [WAYS-1:0] i_data_we,
	input wire logic [WAYS-1:0] i_valid_we,
	input wire logic [IW-1:0] i_wr_index,
	input wire tlb_mmap_pkg::tag_entry_t i_wr_tag,
	input wire tlb_mmap_pkg::data_entry_t i_wr_data,
	input wire logic i_wr_valid,
	input wire logic [IW-1:0] i_rd_index_a,
	input wire logic [IW-1:0] i_rd_index_b,
	output var tlb_mmap_pkg::tag_entry_t [WAYS-1:0] o_tag_a,
	output var tlb_mmap_pkg::data_entry_t [WAYS-1:0] o_data_a,
	output var logic [WAYS-1:0] o_valid_a,
	output var tlb_mmap_pkg::tag_entry_t [WAYS-1:0] o_tag_b,
	output var tlb_mmap_pkg::data_entry_t [WAYS-1:0] o_data_b,
	output var logic [WAYS-1:0] o_valid_b
);
	import tlb_mmap_pkg::*;

	// ----------------------------------------------------------------
	// storage, one generate branch per way
	// ----------------------------------------------------------------
	for (genvar w = 0; w < WAYS; w++)
	begin : g_way
		tag_entry_t [SETS-1:0] tag_mem_reg;
		data_entry_t [SETS-1:0] data_mem_reg;
		logic [SETS-1:0] valid_mem_reg;

		// cleared so an early associative compare never sees unknowns
		always_ff @(posedge clk)
		begin
			if (!rst_n)
				tag_mem_reg <= '0;
			else if (i_tag_we[w])
				tag_mem_reg[i_wr_index] <= i_wr_tag;
		end

		always_ff @(posedge clk)
		begin
			if (!rst_n)
				data_mem_reg <= '0;
			else if (i_data_we[w])
				data_mem_reg[i_wr_index] <= i_wr_data;
		end

		always_ff @(posedge clk)
		begin
			if (!rst_n)
				valid_mem_reg <= '0;
			else if (i_valid_we[w])
				valid_mem_reg[i_wr_index] <= i_wr_valid;
		end

		assign o_tag_a[w] = tag_mem_reg[i_rd_index_a];
		assign o_data_a[w] = data_mem_reg[i_rd_index_a];
		assign o_valid_a[w] = valid_mem_reg[i_rd_index_a];
		assign o_tag_b[w] = tag_mem_reg[i_rd_index_b];
		assign o_data_b[w] = data_mem_reg[i_rd_index_b];
		assign o_valid_b[w] = valid_mem_reg[i_rd_index_b];
	end

endmodule : tlb_set_store

`default_nettype wire

// [design/tlb_memory_mapped_access.sv]
// software window onto a four-way translation buffer over AHB-Lite
// assumes one master, single word transfers, privilege level given as a level input
//
// Summary of operation
// [RULE1] array accesses only take effect while the privilege level bit is set
// [RULE2] both windows sit in the topmost control region of the address space
// [RULE3] top byte F2 selects the tag array: page number, valid, space identifier
// [RULE4] top byte F3 selects the data array: frame number and attributes
// [RULE5] valid flag also readable and writable through the data window
// [RULE6] only longword transfers are served; other sizes are ignored
// [RULE7] tag access: index from bits 16-12, way from bits 9-8
// [RULE8] data access: index from bits 16-12, way 0 to 3 from bits 9-8
// [RULE9] index optionally XORed with space identifier per index hash select
// [RULE10] tag read returns page number, valid and identifier of chosen entry
// [RULE11] plain tag write stores data into the addressed entry and way
// [RULE12] data reads and writes move the whole word of the chosen entry
// [RULE13] associative tag write updates only the matching way; no match, no change
// [RULE14] writing valid zero invalidates the entry so lookups miss
// [RULE15] software changes mappings only with translation off or from fixed regions
// [RULE16] software waits two instructions before touching translated regions
// [RULE17] other address bits ignored; unused read bits return zero
// [RULE18] thirty-two sets of four ways
//
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tlb_mmap_defs.svh"

module tlb_memory_mapped_access #(
	parameter int SETS = 32,
	parameter int WAYS = 4
) (
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [2:0] I_HSIZE,
	input wire logic [31:0] I_HWDATA,
	input wire logic I_HREADY,
	output logic [31:0] O_HRDATA,
	output logic O_HREADYOUT,
	output logic O_HRESP,
	input wire logic I_PRIVILEGE_LEVEL_BIT,
	input wire logic I_LOOKUP_REQ,
	input wire logic [31:0] I_LOOKUP_VA,
	output logic O_LOOKUP_DONE,
	output logic O_LOOKUP_HIT,
	output tlb_mmap_pkg::data_entry_t O_LOOKUP_ENTRY
);
	import tlb_mmap_pkg::*;

	localparam int IW = `IDX_MSB - `IDX_LSB + 1;
	localparam int WW = `WAY_MSB - `WAY_LSB + 1;

	// address fields fix the geometry, so nothing else can be served
	if (SETS != (1 << IW) || WAYS != (1 << WW))
	begin : g_bad_geometry
		$error("SETS and WAYS must match the index and way address fields"); // RULE18
	end

	// ----------------------------------------------------------------
	// bus phase tracking
	// ----------------------------------------------------------------
	bus_state_t state_reg;
	bus_phase_t phase_reg;
	logic take;
	logic ready_state;

	assign ready_state = (state_reg != ST_READ_WAIT);
	assign take = I_HSEL && I_HTRANS[1] && I_HREADY && ready_state;

	always_ff @(posedge I_CLK)
	begin
		if (!I_RST_N)
			state_reg <= ST_IDLE;
		else
		begin
			case (state_reg)
				ST_IDLE, ST_WRITE, ST_READ_DONE:
					if (take)
						state_reg <= I_HWRITE ? ST_WRITE : ST_READ_WAIT;
					else
						state_reg <= ST_IDLE;
				ST_READ_WAIT:
					state_reg <= ST_READ_DONE;
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge I_CLK)
	begin
		if (!I_RST_N)
			phase_reg <= '0;
		else if (take)
		begin
			phase_reg.addr <= I_HADDR;
			phase_reg.write <= I_HWRITE;
			phase_reg.word <= (I_HSIZE == `HSIZE_WORD); // RULE6
			phase_reg.priv <= I_PRIVILEGE_LEVEL_BIT; // RULE1
		end
	end

	// ----------------------------------------------------------------
	// decode of the latched address
	// ----------------------------------------------------------------
	logic is_tag;
	logic is_data;
	logic is_ctrl;
	logic acc_ok;
	logic assoc;
	logic [WW-1:0] way;
	logic [IW-1:0] idx;
	logic ctrl_en_reg;
	logic hash_sel_reg;
	logic [`CTRL_SPACE_MSB-`CTRL_SPACE_LSB:0] space_id_reg;
	logic [IW-1:0] hash_mask;

	assign is_tag = (phase_reg.addr[`WIN_MSB:`WIN_LSB] == `WIN_TAG); // RULE2 RULE3 RULE7
	assign is_data = (phase_reg.addr[`WIN_MSB:`WIN_LSB] == `WIN_DATA); // RULE2 RULE4 RULE8
	assign is_ctrl = (phase_reg.addr == `CTRL_ADDR);
	assign acc_ok = phase_reg.word && phase_reg.priv; // RULE1 RULE6
	assign assoc = phase_reg.addr[`ASSOC_BIT];
	assign way = phase_reg.addr[`WAY_MSB:`WAY_LSB]; // RULE7 RULE8
	assign hash_mask = hash_sel_reg ? space_id_reg[IW-1:0] : '0;
	assign idx = phase_reg.addr[`IDX_MSB:`IDX_LSB] ^ hash_mask; // RULE9 RULE17

	// ----------------------------------------------------------------
	// storage and associative compare
	// ----------------------------------------------------------------
	tag_entry_t [WAYS-1:0] rd_tag_a;
	data_entry_t [WAYS-1:0] rd_data_a;
	logic [WAYS-1:0] rd_valid_a;
	tag_entry_t [WAYS-1:0] rd_tag_b;
	data_entry_t [WAYS-1:0] rd_data_b;
	logic [WAYS-1:0] rd_valid_b;
	logic [WAYS-1:0] tag_we;
	logic [WAYS-1:0] data_we;
	logic [WAYS-1:0] valid_we;
	logic [WAYS-1:0] match_vec;
	logic [WAYS-1:0] lk_match;
	logic [IW-1:0] lk_idx;
	tag_entry_t wr_tag;
	data_entry_t wr_data;
	logic wr_valid;
	logic wr_phase;

	assign wr_tag.vpage_hi = I_HWDATA[`TAG_VPNH_MSB:`TAG_VPNH_LSB];
	assign wr_tag.vpage_lo = I_HWDATA[`TAG_VPNL_MSB:`TAG_VPNL_LSB];
	assign wr_tag.space_id = I_HWDATA[`TAG_SPACE_MSB:`TAG_SPACE_LSB];
	assign wr_data.frame = I_HWDATA[`DAT_FRAME_MSB:`DAT_FRAME_LSB];
	assign wr_data.rights = I_HWDATA[`DAT_RIGHTS_MSB:`DAT_RIGHTS_LSB];
	assign wr_data.page_size = I_HWDATA[`DAT_SIZE_BIT];
	assign wr_data.cacheable = I_HWDATA[`DAT_CACHE_BIT];
	assign wr_data.dirty = I_HWDATA[`DAT_DIRTY_BIT];
	assign wr_data.share = I_HWDATA[`DAT_SHARE_BIT];
	assign wr_valid = I_HWDATA[`VALID_BIT]; // RULE14
	assign wr_phase = (state_reg == ST_WRITE) && acc_ok;
	assign lk_idx = I_LOOKUP_VA[`IDX_MSB:`IDX_LSB] ^ hash_mask; // RULE9

	tlb_set_store #(
		.SETS(SETS),
		.WAYS(WAYS),
		.IW(IW)
	) tlb_set_store_i (
		.clk(I_CLK),
		.rst_n(I_RST_N),
		.i_tag_we(tag_we),
		.i_data_we(data_we),
		.i_valid_we(valid_we),
		.i_wr_index(idx),
		.i_wr_tag(wr_tag),
		.i_wr_data(wr_data),
		.i_wr_valid(wr_valid),
		.i_rd_index_a(idx),
		.i_rd_index_b(lk_idx),
		.o_tag_a(rd_tag_a),
		.o_data_a(rd_data_a),
		.o_valid_a(rd_valid_a),
		.o_tag_b(rd_tag_b),
		.o_data_b(rd_data_b),
		.o_valid_b(rd_valid_b)
	);

	for (genvar w = 0; w < WAYS; w++)
	begin : g_cmp
		// stored valid is not part of the compare, so a dead entry can be revived
		assign match_vec[w] = (rd_tag_a[w] == wr_tag); // RULE13
		assign lk_match[w] = rd_valid_b[w] // RULE14
			&& rd_tag_b[w].vpage_hi == I_LOOKUP_VA[`TAG_VPNH_MSB:`TAG_VPNH_LSB]
			&& rd_tag_b[w].vpage_lo == I_LOOKUP_VA[`TAG_VPNL_MSB:`TAG_VPNL_LSB]
			&& rd_tag_b[w].space_id == space_id_reg;
	end

	always_comb
	begin
		tag_we = '0;
		data_we = '0;
		valid_we = '0;
		if (wr_phase && is_tag)
		begin
			if (assoc)
				valid_we = match_vec; // RULE13
			else
			begin
				tag_we[way] = 1'b1; // RULE11
				valid_we[way] = 1'b1; // RULE14
			end
		end
		else if (wr_phase && is_data)
		begin
			data_we[way] = 1'b1; // RULE12
			valid_we[way] = 1'b1; // RULE5
		end
	end

	// ----------------------------------------------------------------
	// translation control register
	// ----------------------------------------------------------------
	always_ff @(posedge I_CLK)
	begin
		if (!I_RST_N)
		begin
			ctrl_en_reg <= 1'b0;
			hash_sel_reg <= 1'b0;
			space_id_reg <= '0;
		end
		else if (wr_phase && is_ctrl)
		begin
			ctrl_en_reg <= I_HWDATA[`CTRL_EN_BIT];
			hash_sel_reg <= I_HWDATA[`CTRL_HASH_BIT];
			space_id_reg <= I_HWDATA[`CTRL_SPACE_MSB:`CTRL_SPACE_LSB];
		end
	end

	// ----------------------------------------------------------------
	// read data and bus answer
	// ----------------------------------------------------------------
	logic [31:0] read_word;

	always_comb
	begin
		read_word = '0; // RULE17
		if (acc_ok && is_tag)
		begin
			read_word[`TAG_VPNH_MSB:`TAG_VPNH_LSB] = rd_tag_a[way].vpage_hi; // RULE10
			read_word[`TAG_VPNL_MSB:`TAG_VPNL_LSB] = rd_tag_a[way].vpage_lo;
			read_word[`VALID_BIT] = rd_valid_a[way];
			read_word[`TAG_SPACE_MSB:`TAG_SPACE_LSB] = rd_tag_a[way].space_id;
		end
		else if (acc_ok && is_data)
		begin
			read_word[`DAT_FRAME_MSB:`DAT_FRAME_LSB] = rd_data_a[way].frame; // RULE12
			read_word[`DAT_RIGHTS_MSB:`DAT_RIGHTS_LSB] = rd_data_a[way].rights;
			read_word[`DAT_SIZE_BIT] = rd_data_a[way].page_size;
			read_word[`DAT_CACHE_BIT] = rd_data_a[way].cacheable;
			read_word[`DAT_DIRTY_BIT] = rd_data_a[way].dirty;
			read_word[`DAT_SHARE_BIT] = rd_data_a[way].share;
			read_word[`VALID_BIT] = rd_valid_a[way]; // RULE5
		end
		else if (acc_ok && is_ctrl)
		begin
			read_word[`CTRL_EN_BIT] = ctrl_en_reg;
			read_word[`CTRL_HASH_BIT] = hash_sel_reg;
			read_word[`CTRL_SPACE_MSB:`CTRL_SPACE_LSB] = space_id_reg;
		end
	end

	// one wait state on reads lets a write in the previous data phase land first
	always_ff @(posedge I_CLK)
	begin
		if (!I_RST_N)
			O_HREADYOUT <= 1'b1;
		else if (state_reg == ST_READ_WAIT)
			O_HREADYOUT <= 1'b1;
		else
			O_HREADYOUT <= !(take && !I_HWRITE);
	end

	always_ff @(posedge I_CLK)
	begin
		if (!I_RST_N)
			O_HRDATA <= '0;
		else if (state_reg == ST_READ_WAIT)
			O_HRDATA <= read_word;
		else
			O_HRDATA <= '0;
	end

	always_ff @(posedge I_CLK)
	begin
		O_HRESP <= 1'b0;
	end

	// ----------------------------------------------------------------
	// translation lookup, page size not applied
	// ----------------------------------------------------------------
	data_entry_t lk_entry;

	always_comb
	begin
		lk_entry = '0;
		for (int w = WAYS - 1; w >= 0; w--)
		begin
			if (lk_match[w])
				lk_entry = rd_data_b[w];
		end
	end

	always_ff @(posedge I_CLK)
	begin
		if (!I_RST_N)
		begin
			O_LOOKUP_DONE <= 1'b0;
			O_LOOKUP_HIT <= 1'b0;
			O_LOOKUP_ENTRY <= '0;
		end
		else
		begin
			O_LOOKUP_DONE <= I_LOOKUP_REQ;
			O_LOOKUP_HIT <= I_LOOKUP_REQ && ctrl_en_reg && (|lk_match); // RULE14
			O_LOOKUP_ENTRY <= (I_LOOKUP_REQ && ctrl_en_reg) ? lk_entry : '0;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);

	priv_gate_a: assert property ((state_reg == ST_WRITE) && !phase_reg.priv // RULE1
		|-> (tag_we == '0) && (data_we == '0) && (valid_we == '0))
		else $error("array written outside privileged mode");
	word_only_a: assert property ((state_reg == ST_WRITE) && !phase_reg.word // RULE6
		|-> (tag_we | data_we | valid_we) == '0)
		else $error("non-word transfer changed the arrays");
	read_wait_a: assert property (take && !I_HWRITE // RULE10
		|=> !O_HREADYOUT ##1 O_HREADYOUT)
		else $error("read answer not after exactly one wait state");
	unmapped_zero_a: assert property ((state_reg == ST_READ_WAIT) // RULE17
		&& !(is_tag || is_data || is_ctrl) |=> O_HRDATA == 32'h0000_0000)
		else $error("unmapped read returned nonzero data");
	tag_fields_a: assert property ((state_reg == ST_READ_WAIT) && acc_ok && is_tag // RULE10
		|=> ((O_HRDATA & ~`TAG_MASK) == '0) && O_HRDATA[`VALID_BIT] == $past(rd_valid_a[way]))
		else $error("tag read format wrong");
	data_valid_a: assert property ((state_reg == ST_READ_WAIT) && acc_ok && is_data // RULE5
		|=> ((O_HRDATA & ~`DAT_MASK) == '0) && O_HRDATA[`VALID_BIT] == $past(rd_valid_a[way]))
		else $error("data read format or valid flag wrong");
	assoc_match_a: assert property (wr_phase && is_tag && assoc // RULE13
		|-> (tag_we == '0) && (valid_we == match_vec))
		else $error("associative write touched a non-matching way");
	direct_write_a: assert property (wr_phase && is_tag && !assoc // RULE11
		|-> $onehot(tag_we) && tag_we[way] && valid_we == tag_we)
		else $error("direct tag write selected the wrong way");
	hash_index_a: assert property (idx == (phase_reg.addr[`IDX_MSB:`IDX_LSB] // RULE9
		^ (hash_sel_reg ? space_id_reg[IW-1:0] : '0)))
		else $error("entry index not formed from hash select");
	okay_only_a: assert property (O_HRESP == 1'b0 && (O_HREADYOUT || $past(take)))
		else $error("response not okay or wait too long");

	read_tag_c: cover property ((state_reg == ST_READ_WAIT) && acc_ok && is_tag);
	assoc_hit_c: cover property (wr_phase && is_tag && assoc && (|match_vec));
	lookup_hit_c: cover property (O_LOOKUP_HIT);

endmodule : tlb_memory_mapped_access

`default_nettype wire

// [verif/tlb_memory_mapped_access_tb_top.sv]
// self-checking bench for the memory-mapped translation buffer access block
// assumes the design's package and defines header on the include path
`timescale 1ns/1ps
`default_nettype none
`include "tlb_mmap_defs.svh"

module tlb_memory_mapped_access_tb_top;
	import tlb_mmap_pkg::*;

	typedef struct {
		logic wr;
		logic [31:0] a;
		logic [31:0] d;
	} row_t;

	logic clk;
	logic rst_n;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic priv;
	logic lreq;
	logic [31:0] lva;
	logic ldone;
	logic lhit;
	data_entry_t lentry;
	int n_fail;
	int samples_checked;
	int cyc;
	logic [31:0] rd;
	row_t rows [8];

	// ----------------------------------------------------------------
	// clock, design, watchdog
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	tlb_memory_mapped_access tlb_memory_mapped_access_i (
		.I_CLK(clk),
		.I_RST_N(rst_n),
		.I_HSEL(hsel),
		.I_HADDR(haddr),
		.I_HTRANS(htrans),
		.I_HWRITE(hwrite),
		.I_HSIZE(hsize),
		.I_HWDATA(hwdata),
		.I_HREADY(hreadyout),
		.O_HRDATA(hrdata),
		.O_HREADYOUT(hreadyout),
		.O_HRESP(hresp),
		.I_PRIVILEGE_LEVEL_BIT(priv),
		.I_LOOKUP_REQ(lreq),
		.I_LOOKUP_VA(lva),
		.O_LOOKUP_DONE(ldone),
		.O_LOOKUP_HIT(lhit),
		.O_LOOKUP_ENTRY(lentry)
	);

	// whole run is little more than a hundred cycles; generous ceiling
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_fail++;
			$display("ERROR watchdog expected 0 seen %0d", cyc);
			conclude();
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("checked %0d, failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude

	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_word

	task automatic chk_look(input string what, input logic exp_hit, input data_entry_t exp_e);
		samples_checked++;
		if (ldone !== 1'b1 || lhit !== exp_hit || lentry !== exp_e)
		begin
			n_fail++;
			$display("ERROR %s expected %b/%h seen %b/%b/%h", what, exp_hit, exp_e, ldone,
				lhit, lentry);
		end
	endtask : chk_look

	// entered just after a rising edge; read data taken at the data-phase ready edge
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		input logic [2:0] sz, input logic pv, output logic [31:0] rdata);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		hsize <= sz;
		priv <= pv;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rdata = hrdata;
		chk_word("hresp", 32'h0000_0000, {31'h0, hresp});
	endtask : ahb

	task automatic wr_w(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		ahb(1'b1, a, d, `HSIZE_WORD, 1'b1, dummy);
	endtask : wr_w

	task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] got;
		ahb(1'b0, a, 32'h0000_0000, `HSIZE_WORD, 1'b1, got);
		chk_word(what, exp, got);
	endtask : rd_chk

	task automatic lookup(input logic [31:0] va, input logic exp_hit, input logic [31:0] w);
		data_entry_t e;
		e = exp_hit ? data_entry_t'({w[28:10], w[6:1]}) : data_entry_t'(0);
		lreq <= 1'b1;
		lva <= va;
		@(posedge clk);
		lreq <= 1'b0;
		#1;
		chk_look("lookup", exp_hit, e);
		@(posedge clk);
	endtask : lookup

	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask : do_reset

	// ----------------------------------------------------------------
	// stimulus
	// ----------------------------------------------------------------
	initial
	begin
		cyc = 0;
		n_fail = 0;
		samples_checked = 0;
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = `HSIZE_WORD;
		hwdata = 32'h0000_0000;
		priv = 1'b1;
		lreq = 1'b0;
		lva = 32'h0000_0000;
		rows = '{
			'{1'b0, 32'hF201_3100, 32'h0000_0000},
			'{1'b1, 32'hF201_3100, 32'h1547_391C},
			'{1'b0, 32'hF201_3100, 32'h1546_091C},
			'{1'b1, 32'hF301_3100, 32'hFFFF_FFFF},
			'{1'b0, 32'hF301_3100, 32'h1FFF_FD7E},
			'{1'b1, 32'hF301_3100, 32'h0ABC_D56A},
			'{1'b0, 32'hF2FD_3142, 32'h1546_091C},
			'{1'b0, 32'hF300_3100, 32'h0000_0000}
		};
		do_reset();
		for (int k = 0; k < 8; k++)
		begin
			ahb(rows[k].wr, rows[k].a, rows[k].d, `HSIZE_WORD, 1'b1, rd);
			if (!rows[k].wr)
				chk_word("row read", rows[k].d, rd);
		end
		rd_chk("data back", 32'hF301_3100, 32'h0ABC_D56A);
		wr_w(32'hF201_3000, 32'h2222_2D05);
		rd_chk("way0 tag", 32'hF201_3000, 32'h2222_0D05);
		// refused writes leave the entry alone
		ahb(1'b1, 32'hF201_3100, 32'h0000_0000, `HSIZE_WORD, 1'b0, rd);
		ahb(1'b0, 32'hF201_3100, 32'h0000_0000, `HSIZE_WORD, 1'b0, rd);
		chk_word("user read", 32'h0000_0000, rd);
		ahb(1'b1, 32'hF201_3100, 32'h0000_0000, 3'h1, 1'b1, rd);
		rd_chk("after user/half", 32'hF201_3100, 32'h1546_091C);
		wr_w(32'hF401_3100, 32'hFFFF_FFFF);
		rd_chk("unmapped", 32'hF401_3100, 32'h0000_0000);
		// enable translation, space identifier 1C
		wr_w(`CTRL_ADDR, 32'h0000_1C01);
		repeat (2) @(posedge clk);
		lookup(32'h1547_3800, 1'b1, 32'h0ABC_D56A);
		// associative miss: nothing changes
		wr_w(32'hF201_3080, 32'h3333_381C);
		rd_chk("assoc miss w1", 32'hF201_3100, 32'h1546_091C);
		rd_chk("assoc miss w0", 32'hF201_3000, 32'h2222_0D05);
		// associative hit with valid zero clears only the matching way
		wr_w(32'hF201_3080, 32'h1547_381C);
		rd_chk("assoc hit w1", 32'hF201_3100, 32'h1546_081C);
		rd_chk("assoc hit w0", 32'hF201_3000, 32'h2222_0D05);
		rd_chk("valid via data", 32'hF301_3100, 32'h0ABC_D46A);
		lookup(32'h1547_3800, 1'b0, 32'h0000_0000);
		// data window rewrite sets valid again, visible in tag window
		wr_w(32'hF301_3100, 32'h0ABC_D56A);
		rd_chk("valid via tag", 32'hF201_3100, 32'h1546_091C);
		// hashed index: window index 0F maps onto set 13
		wr_w(`CTRL_ADDR, 32'h0000_1C05);
		rd_chk("control back", `CTRL_ADDR, 32'h0000_1C05);
		rd_chk("hashed tag", 32'hF200_F100, 32'h1546_091C);
		rd_chk("hashed data", 32'hF300_F100, 32'h0ABC_D56A);
		// translation off refuses hits
		wr_w(`CTRL_ADDR, 32'h0000_1C00);
		lookup(32'h1547_3800, 1'b0, 32'h0000_0000);
		do_reset();
		rd_chk("reset tag", 32'hF201_3100, 32'h0000_0000);
		rd_chk("reset data", 32'hF301_3100, 32'h0000_0000);
		rd_chk("reset control", `CTRL_ADDR, 32'h0000_0000);
		conclude();
	end

endmodule : tlb_memory_mapped_access_tb_top
`default_nettype wire
